// ==== design/mata_map.svh ====
`ifndef MATA_MAP_SVH
`define MATA_MAP_SVH

// register byte offsets within the 4 KiB window
`define MATA_OFF_MAIN_CTRL 12'h410
`define MATA_OFF_STAT_CTRL 12'h414
`define MATA_OFF_WORD1     12'h420
`define MATA_OFF_WORD2     12'h424
`define MATA_OFF_WORD3     12'h428
`define MATA_OFF_WORD4     12'h42c

// writable bits of each data word, reserved bits stay zero
`define MATA_W1_MASK       32'hfc000007
`define MATA_W2_MASK_MAIN  32'h8000007f
`define MATA_W2_MASK_STAT  32'hc000007f
`define MATA_W3_MASK       32'h007fffff
`define MATA_W4_MASK       32'hffffffff

// control register fields
`define MATA_CTL_GO_BIT    31
`define MATA_MCTL_ACT_HI   29
`define MATA_MCTL_ACT_LO   28
`define MATA_SCTL_ACT_BIT  9
`define MATA_SCTL_SEL_BIT  8

// action codes of the main table control
`define MATA_ACT_WRITE     2'h1
`define MATA_ACT_READ      2'h2
`define MATA_ACT_SEARCH    2'h3

// age value reloaded on learn or access
`define MATA_AGE_DEFAULT   3'h7

`endif

// ==== design/mata_pkg.sv ====
`default_nettype none
`include "mata_map.svh"
package mata_pkg;
    // one table entry, both tables share the layout
    typedef struct packed {
        logic        flag;      // static (main) or valid (static table)
        logic        sdrop;
        logic        ddrop;
        logic [2:0]  pa;        // priority or entry_age_value
        logic        ufid;
        logic        ovr;
        logic [6:0]  fwd;
        logic [6:0]  filter_group_id;
        logic [47:0] mac;
        logic [2:0]  stg;
    } mata_entry_t;

    typedef logic [3:0][31:0] mata_words_t;

    // lookup request from the forwarding path
    typedef struct packed {
        logic [47:0] da;
        logic [47:0] sa;
        logic [6:0]  filter_group_id;
        logic [2:0]  stg;
        logic [2:0]  port;
    } mata_lk_req_t;

    // registered lookup answer
    typedef struct packed {
        logic       hit;
        logic       stat;
        logic       drop;
        logic       ovr;
        logic [6:0] fwd;
    } mata_lk_res_t;

    typedef enum logic [2:0] {
        MATA_IDLE  = 3'h0,
        MATA_SOP   = 3'h1,
        MATA_MRD   = 3'h3,
        MATA_MWR   = 3'h2,
        MATA_SRCH  = 3'h6,
        MATA_SHOLD = 3'h7
    } mata_state_t;

    function automatic mata_words_t mata_pack(input mata_entry_t e);
        mata_words_t w;
        w[0] = {e.flag, e.sdrop, e.ddrop, e.pa, 23'h0, e.stg};
        w[1] = {e.ovr, e.ufid, 23'h0, e.fwd};
        w[2] = {9'h0, e.filter_group_id, e.mac[47:32]};
        w[3] = e.mac[31:0];
        return w;
    endfunction

    function automatic mata_entry_t mata_unpack(input mata_words_t w);
        mata_entry_t e;
        e = '{w[0][31], w[0][30], w[0][29], w[0][28:26], w[1][30], w[1][31],
              w[1][6:0], w[2][22:16], {w[2][15:0], w[3]}, w[0][2:0]};
        return e;
    endfunction
endpackage
`default_nettype wire

// ==== design/mata_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mata_map.svh"
module mata_top #(
    parameter int MAIN_DEPTH = 16,
    parameter int STAT_DEPTH = 16
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // lookup path
    input  wire logic                  lk_req,
    input  wire mata_pkg::mata_lk_req_t lk_in,
    input  wire logic                  age_tick,
    output logic                       res_valid,
    output mata_pkg::mata_lk_res_t     res_out
);
    import mata_pkg::*;

    localparam int MIW = $clog2(MAIN_DEPTH);
    localparam int SIW = $clog2(STAT_DEPTH);

    // tables
    mata_entry_t main_q [MAIN_DEPTH];
    mata_entry_t stat_q [STAT_DEPTH];

    // bus side state
    logic [11:0]  a_addr_q;
    logic         wr_pend_q;
    logic         rd_pend_q;
    logic         hready_q;
    logic [31:0]  hrdata_q;
    logic         hresp_q;

    // indirect access state
    mata_words_t  data_q;
    logic         view_stat_q;
    mata_state_t  st_q;
    logic         mgo_q;
    logic         mvalid_q;
    logic [1:0]   mact_q;
    logic [11:0]  midx_q;
    logic         sgo_q;
    logic         ssel_q;
    logic         sact_q;
    logic [3:0]   sidx_q;
    logic [MIW-1:0] ptr_q;

    // lookup results
    logic         res_valid_q;
    mata_lk_res_t res_q;

    // address decode of the captured data phase
    wire logic ahb_take = hsel && htrans[1] && hready;
    wire logic [3:0] wr_w = {4{wr_pend_q}} & {a_addr_q == `MATA_OFF_WORD4, a_addr_q == `MATA_OFF_WORD3,
                                              a_addr_q == `MATA_OFF_WORD2, a_addr_q == `MATA_OFF_WORD1};
    wire logic wr_mctl = wr_pend_q && a_addr_q == `MATA_OFF_MAIN_CTRL;
    wire logic wr_sctl = wr_pend_q && a_addr_q == `MATA_OFF_STAT_CTRL;
    wire logic rd_w4   = rd_pend_q && a_addr_q == `MATA_OFF_WORD4;

    // the word2 write mask depends on the current view, the other masks are fixed
    wire logic [31:0] w2_mask = view_stat_q ? `MATA_W2_MASK_STAT : `MATA_W2_MASK_MAIN;
    wire mata_words_t wmask = {`MATA_W4_MASK, `MATA_W3_MASK, w2_mask, `MATA_W1_MASK};

    // read mux
    wire logic [31:0] mctl_rd = {mgo_q, mvalid_q, mact_q, 16'h0, midx_q};
    wire logic [31:0] sctl_rd = {sgo_q, 21'h0, sact_q, ssel_q, 4'h0, sidx_q};
    wire logic [31:0] rd_mux =
        (a_addr_q == `MATA_OFF_WORD1)     ? data_q[0] :
        (a_addr_q == `MATA_OFF_WORD2)     ? data_q[1] :
        (a_addr_q == `MATA_OFF_WORD3)     ? data_q[2] :
        (a_addr_q == `MATA_OFF_WORD4)     ? data_q[3] :
        (a_addr_q == `MATA_OFF_MAIN_CTRL) ? mctl_rd   :
        (a_addr_q == `MATA_OFF_STAT_CTRL) ? sctl_rd   : 32'h0;

    // entry under the main control index and the search pointer
    wire logic [MIW-1:0] midx = midx_q[MIW-1:0];
    wire logic [SIW-1:0] sidx = sidx_q[SIW-1:0];
    wire logic ptr_last = ptr_q == MIW'(MAIN_DEPTH - 1);

    function automatic logic ent_live(input mata_entry_t e);
        return e.flag || (e.pa != 3'h0);
    endfunction

    function automatic logic ent_match(input mata_entry_t e, input logic [47:0] mac,
                                       input logic [6:0] filter_group_id, input logic [2:0] stg);
        return e.mac == mac && e.filter_group_id == filter_group_id && e.stg == stg;
    endfunction

    wire logic ptr_live  = ent_live(main_q[ptr_q]);
    wire logic midx_live = ent_live(main_q[midx]);

    // hardware loads of the data words
    wire logic ld_stat  = st_q == MATA_SOP && !ssel_q && sact_q;
    wire logic ld_mrd   = st_q == MATA_MRD;
    wire logic ld_find  = st_q == MATA_SRCH && mgo_q && ptr_live;
    wire logic ld_zero  = mgo_q && ((st_q == MATA_SRCH && !ptr_live && ptr_last) ||
                                    (st_q == MATA_SHOLD && rd_w4 && ptr_last));
    wire mata_words_t stat_words = mata_pack(stat_q[sidx]);
    wire mata_words_t mrd_words  = midx_live ? mata_pack(main_q[midx]) : '0;
    wire mata_words_t ptr_words  = mata_pack(main_q[ptr_q]);

    // bus slave: writes take no wait, reads one wait state so a write just before is seen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_addr_q  <= 12'h0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hready_q  <= 1'b1;
            hrdata_q  <= 32'h0;
            hresp_q   <= 1'b0;
        end else begin
            if (ahb_take) begin
                a_addr_q <= haddr[11:0];
            end
            wr_pend_q <= ahb_take && hwrite;
            rd_pend_q <= ahb_take && !hwrite;
            hready_q  <= !(ahb_take && !hwrite);
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
            hresp_q <= 1'b0; // always okay
        end
    end

    // data words: software writes masked, hardware loads after them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (wr_w[k]) begin
                    data_q[k] <= hwdata & wmask[k];
                end
            end
            if (ld_stat) begin
                data_q <= stat_words;
            end else if (ld_mrd) begin
                data_q <= mrd_words;
            end else if (ld_find) begin
                data_q <= ptr_words;
            end else if (ld_zero) begin
                data_q <= '0;
            end
        end
    end

    // control registers and the indirect access sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q        <= MATA_IDLE;
            mgo_q       <= 1'b0;
            mvalid_q    <= 1'b0;
            mact_q      <= 2'h0;
            midx_q      <= 12'h0;
            sgo_q       <= 1'b0;
            ssel_q      <= 1'b0;
            sact_q      <= 1'b0;
            sidx_q      <= 4'h0;
            ptr_q       <= '0;
            view_stat_q <= 1'b0;
        end else begin
            case (st_q)
                MATA_IDLE: begin
                    if (sgo_q) begin
                        st_q <= MATA_SOP;
                    end else if (mgo_q) begin
                        view_stat_q <= 1'b0;
                        ptr_q       <= '0;
                        mvalid_q    <= 1'b0;
                        case (mact_q)
                            `MATA_ACT_READ:   st_q <= MATA_MRD;
                            `MATA_ACT_WRITE:  st_q <= MATA_MWR;
                            `MATA_ACT_SEARCH: st_q <= MATA_SRCH;
                            default:          mgo_q <= 1'b0;
                        endcase
                    end
                end
                MATA_SOP: begin
                    view_stat_q <= !ssel_q;
                    sgo_q       <= 1'b0;
                    st_q        <= MATA_IDLE;
                end
                MATA_MRD: begin
                    mvalid_q <= midx_live;
                    mgo_q    <= 1'b0;
                    st_q     <= MATA_IDLE;
                end
                MATA_MWR: begin
                    mgo_q <= 1'b0;
                    st_q  <= MATA_IDLE;
                end
                MATA_SRCH: begin
                    if (!mgo_q) begin
                        st_q <= MATA_IDLE; // stopped by software
                    end else if (ptr_live) begin
                        mvalid_q <= 1'b1;
                        st_q     <= MATA_SHOLD;
                    end else if (ptr_last) begin
                        mgo_q <= 1'b0;
                        st_q  <= MATA_IDLE;
                    end else begin
                        ptr_q <= ptr_q + 1'b1;
                    end
                end
                MATA_SHOLD: begin
                    if (!mgo_q) begin
                        st_q <= MATA_IDLE;
                    end else if (rd_w4) begin
                        mvalid_q <= 1'b0;
                        if (ptr_last) begin
                            mgo_q <= 1'b0;
                            st_q  <= MATA_IDLE;
                        end else begin
                            ptr_q <= ptr_q + 1'b1;
                            st_q  <= MATA_SRCH;
                        end
                    end
                end
                default: st_q <= MATA_IDLE;
            endcase
            // software writes come last so a set is never lost to a clear
            if (wr_mctl) begin
                mgo_q  <= hwdata[`MATA_CTL_GO_BIT];
                mact_q <= hwdata[`MATA_MCTL_ACT_HI:`MATA_MCTL_ACT_LO];
                midx_q <= hwdata[11:0];
            end
            if (wr_sctl) begin
                sgo_q  <= hwdata[`MATA_CTL_GO_BIT];
                sact_q <= hwdata[`MATA_SCTL_ACT_BIT];
                ssel_q <= hwdata[`MATA_SCTL_SEL_BIT];
                sidx_q <= hwdata[3:0];
            end
        end
    end

    // lookup search: destination over both tables, source over the main table only
    logic           da_st_hit;
    logic [SIW-1:0] da_st_idx;
    logic           da_ms_hit;
    logic [MIW-1:0] da_ms_idx;
    logic           da_md_hit;
    logic [MIW-1:0] da_md_idx;
    logic           sa_hit;
    logic [MIW-1:0] sa_idx;
    always_comb begin
        da_st_hit = 1'b0;
        da_st_idx = '0;
        da_ms_hit = 1'b0;
        da_ms_idx = '0;
        da_md_hit = 1'b0;
        da_md_idx = '0;
        sa_hit    = 1'b0;
        sa_idx    = '0;
        for (int i = STAT_DEPTH - 1; i >= 0; i--) begin
            if (stat_q[i].flag && ent_match(stat_q[i], lk_in.da, lk_in.filter_group_id, lk_in.stg)) begin
                da_st_hit = 1'b1;
                da_st_idx = SIW'(i);
            end
        end
        for (int i = MAIN_DEPTH - 1; i >= 0; i--) begin
            if (ent_live(main_q[i]) && ent_match(main_q[i], lk_in.da, lk_in.filter_group_id, lk_in.stg)) begin
                if (main_q[i].flag) begin
                    da_ms_hit = 1'b1;
                    da_ms_idx = MIW'(i);
                end else begin
                    da_md_hit = 1'b1;
                    da_md_idx = MIW'(i);
                end
            end
            if (ent_live(main_q[i]) && ent_match(main_q[i], lk_in.sa, lk_in.filter_group_id, lk_in.stg)) begin
                sa_hit = 1'b1;
                sa_idx = MIW'(i);
            end
        end
    end

    // choose the winning entry, static first
    wire mata_entry_t da_win = da_st_hit ? stat_q[da_st_idx] :
                               da_ms_hit ? main_q[da_ms_idx] : main_q[da_md_idx];
    wire logic da_any  = da_st_hit || da_ms_hit || da_md_hit;
    wire logic sa_drop = sa_hit && main_q[sa_idx].sdrop;
    wire logic [MIW-1:0] learn_idx = MIW'(lk_in.sa[MIW-1:0] ^ lk_in.filter_group_id[MIW-1:0]);
    wire logic [6:0] port_bit = 7'(8'h1 << lk_in.port);
    wire mata_entry_t learned = '{1'b0, 1'b0, 1'b0, `MATA_AGE_DEFAULT, 1'b0, 1'b0,
                                  port_bit, lk_in.filter_group_id, lk_in.sa, lk_in.stg};

    // lookup answer: miss floods nowhere, software decides by hit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            res_valid_q <= 1'b0;
            res_q       <= '0;
        end else begin
            res_valid_q <= lk_req;
            if (lk_req) begin
                res_q.hit  <= da_any;
                res_q.stat <= da_st_hit || da_ms_hit;
                res_q.drop <= sa_drop || (da_any && da_win.ddrop);
                res_q.ovr  <= da_any && da_win.ovr;
                res_q.fwd  <= da_any ? da_win.fwd : 7'h0;
            end
        end
    end

    // main table: software write beats learning, refresh beats aging
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < MAIN_DEPTH; i++) begin
                main_q[i] <= '0;
            end
        end else if (st_q == MATA_MWR) begin
            main_q[midx] <= mata_unpack(data_q);
        end else begin
            if (age_tick) begin
                for (int i = 0; i < MAIN_DEPTH; i++) begin
                    if (!main_q[i].flag && main_q[i].pa != 3'h0) begin
                        main_q[i].pa <= main_q[i].pa - 3'h1;
                    end
                end
            end
            if (lk_req && !sa_hit && !main_q[learn_idx].flag) begin
                main_q[learn_idx] <= learned;
            end else if (lk_req && sa_hit && !main_q[sa_idx].flag) begin
                main_q[sa_idx].pa <= `MATA_AGE_DEFAULT;
            end
            if (lk_req && da_md_hit && !(da_st_hit || da_ms_hit)) begin
                main_q[da_md_idx].pa <= `MATA_AGE_DEFAULT;
            end
        end
    end

    // static table: only the indirect write changes it, a slot per index
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAT_DEPTH; i++) begin
                stat_q[i] <= '0;
            end
        end else if (st_q == MATA_SOP && !ssel_q && !sact_q) begin
            stat_q[sidx] <= mata_unpack(data_q);
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp     = hresp_q;
    assign res_valid = res_valid_q;
    assign res_out   = res_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ahb_read_wait_a : assert property (ahb_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read did not answer after one wait state");
    go_self_clear_a : assert property (st_q == MATA_SOP && !wr_sctl |=> !sgo_q ##1 st_q != MATA_SOP)
        else $error("static go flag did not clear");
    stat_read_load_a : assert property (ld_stat && wr_w == 4'h0 |=> data_q == $past(stat_words))
        else $error("static read did not load the entry");
    stat_keep_a : assert property (!(st_q == MATA_SOP && !ssel_q && !sact_q) |=> $stable(stat_q[0]))
        else $error("static entry changed without a write");
    main_static_a : assert property (main_q[0].flag && st_q != MATA_MWR |=> $stable(main_q[0]))
        else $error("static main entry changed");
    age_step_a : assert property (age_tick && !lk_req && st_q != MATA_MWR && !main_q[0].flag
                                  && main_q[0].pa != 3'h0 |=> main_q[0].pa == $past(main_q[0].pa) - 3'h1)
        else $error("entry_age_value did not decrement");
    age_zero_miss_a : assert property (!main_q[0].flag && main_q[0].pa == 3'h0
                                       |-> !(da_md_hit && da_md_idx == '0))
        else $error("expired entry took part in lookup");
    static_win_a : assert property (lk_req && da_st_hit && da_md_hit |=> res_out.stat && res_valid)
        else $error("dynamic result beat a static one");
    src_drop_a : assert property (lk_req && sa_hit && main_q[sa_idx].sdrop |=> res_out.drop)
        else $error("source drop not applied");
    miss_all_a : assert property (lk_req && !da_any |=> !res_out.hit && res_out.fwd == 7'h0)
        else $error("miss reported a hit");
    search_resume_a : assert property (st_q == MATA_SHOLD && mgo_q && rd_w4 && !ptr_last && !wr_mctl
                                       |=> st_q == MATA_SRCH && !mvalid_q)
        else $error("search did not resume after word4 read");
    resv_zero_a : assert property (data_q[0][25:3] == 23'h0 && data_q[2][31:23] == 9'h0)
        else $error("reserved data bits not zero");
endmodule
`default_nettype wire

// ==== tb/mac_address_table_access_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mata_map.svh"
module mac_address_table_access_tb_top;
    import mata_pkg::*;
    // bench-driven signals
    logic         clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, lk_req = 1'b0, age_tick = 1'b0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]   htrans = 2'h0;
    logic [2:0]   hsize = 3'h2;
    logic         hreadyout, hresp, res_valid;
    mata_lk_req_t lk_in = '0;
    mata_lk_res_t res_out;
    int           num_errors = 0, n_tests = 0, cyc = 0;
    // entry under test: word1 to word4
    logic [31:0]  ent [4] = '{32'h94000002, 32'h80000015, 32'h00110a0b, 32'h0c0d0e0f};
    // entry learned from the lookup source: dynamic, default age, port 0 only
    logic [31:0]  lrn [4] = '{32'h1c000002, 32'h00000001, 32'h00110200, 32'h00000001};

    always #4 clk = ~clk;

    // single slave, so hreadyout is the bus hready
    mata_top dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lk_req(lk_req), .lk_in(lk_in),
        .age_tick(age_tick), .res_valid(res_valid), .res_out(res_out));

    task automatic finish_test();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one ahb-lite single transfer; holds each phase until hready is seen high
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // start an indirect op at control offset a and poll go_done_flag until it drops
    task automatic static_op(input logic [11:0] a, input logic [31:0] ctl);
        int n;
        ahb(1'b1, a, ctl);
        for (n = 0; n < 50; n++) begin
            ahb(1'b0, a, 32'h0);
            if (rd[31] === 1'b0) break;
        end
        check({31'h0, rd[31]}, 32'h0);
    endtask

    // one lookup pulse; answer sampled settled after the taking edge
    task automatic lookup(input logic [10:0] exp);
        lk_req <= 1'b1;
        lk_in  <= '{da: 48'h0a0b0c0d0e0f, sa: 48'h020000000001, filter_group_id: 7'h11, stg: 3'h2, port: 3'h0};
        @(posedge clk);
        lk_req <= 1'b0;
        #1;
        check({31'h0, res_valid}, 32'h1);
        check({21'h0, res_out}, {21'h0, exp});
        @(posedge clk);
    endtask

    initial begin
        int i;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // reset contents, then reserved bits of the main view
        ahb(1'b0, `MATA_OFF_WORD4, 32'h0);
        check(rd, 32'h0);
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, 12'h420 + 12'(4 * i), 32'hffffffff);
        end
        ahb(1'b0, `MATA_OFF_WORD1, 32'h0);
        check(rd, 32'hfc000007);
        ahb(1'b0, `MATA_OFF_WORD2, 32'h0);
        check(rd, 32'h8000007f);
        ahb(1'b0, `MATA_OFF_WORD3, 32'h0);
        check(rd, 32'h007fffff);
        ahb(1'b0, `MATA_OFF_WORD4, 32'h0);
        check(rd, 32'hffffffff);
        // unmapped place reads zero and ignores writes
        ahb(1'b1, 12'h500, 32'h12345678);
        ahb(1'b0, 12'h500, 32'h0);
        check(rd, 32'h0);
        // static write at index 3, wipe the words, read the entry back
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, 12'h420 + 12'(4 * i), ent[i]);
        end
        static_op(`MATA_OFF_STAT_CTRL, 32'h80000003);
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, 12'h420 + 12'(4 * i), 32'h0);
        end
        static_op(`MATA_OFF_STAT_CTRL, 32'h80000203);
        for (i = 0; i < 4; i++) begin
            ahb(1'b0, 12'h420 + 12'(4 * i), 32'h0);
            check(rd, ent[i]);
        end
        // aging passes leave the static entry alone
        for (i = 0; i < 3; i++) begin
            age_tick <= 1'b1;
            @(posedge clk);
            age_tick <= 1'b0;
            @(posedge clk);
        end
        lookup({1'b1, 1'b1, 1'b0, 1'b1, 7'h15});
        // destination drop flag set on the static hit
        ahb(1'b1, `MATA_OFF_WORD1, 32'ha4000002);
        static_op(`MATA_OFF_STAT_CTRL, 32'h80000003);
        lookup({1'b1, 1'b1, 1'b1, 1'b1, 7'h15});
        // valid clear: the entry takes no part
        ahb(1'b1, `MATA_OFF_WORD1, 32'h14000002);
        static_op(`MATA_OFF_STAT_CTRL, 32'h80000003);
        lookup(11'h0);
        // learned source entry read back by a main-table read, then one aging pass
        static_op(`MATA_OFF_MAIN_CTRL, 32'ha0000000);
        for (i = 0; i < 4; i++) begin
            ahb(1'b0, 12'h420 + 12'(4 * i), 32'h0);
            check(rd, lrn[i]);
        end
        age_tick <= 1'b1;
        @(posedge clk);
        age_tick <= 1'b0;
        static_op(`MATA_OFF_MAIN_CTRL, 32'ha0000000);
        ahb(1'b0, `MATA_OFF_WORD1, 32'h0);
        check(rd, 32'h18000002);
        check({31'h0, hresp}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
